// ### pkg/field_measure_cfg.svh
// Constants of the field measurement sequencer
`ifndef FIELD_MEASURE_CFG_SVH
`define FIELD_MEASURE_CFG_SVH
`define CLK_PERIOD_NS 25
`define EOC_PULSE_MIN_NS 1800
`define EOC_PULSE_MAX_NS 3200
`define EOC_PULSE_CYC ((`EOC_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Long enough that even an X/Y cycle outlasts the end pulse in fast mode
`define CONV_CYC_DEF 40
`define LP_STEP_BASE_DEF 64
`endif

// ### pkg/field_measure_pkg.sv
// Types of the field measurement sequencer
package field_measure_pkg;
  typedef enum logic [1:0] {
    CFG_XYZT,
    CFG_XYZ,
    CFG_XY,
    CFG_RSVD
  } chan_cfg_t;
  typedef enum logic [1:0] {
    MODE_LOW_POWER,
    MODE_FAST,
    MODE_HOST,
    MODE_POWER_DOWN
  } run_mode_t;
  typedef enum logic [2:0] {
    CH_X,
    CH_Y,
    CH_Z,
    CH_T
  } chan_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_NEXT
  } seq_state_t;
endpackage

// ### src/wake_timer.sv
// Low power wake timer with eight selectable rates
`timescale 1ns/1ps
`include "field_measure_cfg.svh"
module wake_timer #(
  parameter int unsigned BASE = `LP_STEP_BASE_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [2:0] rate_sel,
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } wt_state_t;
  wt_state_t st_ff;
  wt_state_t nxt_st;
  logic [31:0] limit;
  // Each step doubles the interval; step 0 is fastest
  assign limit = (32'(BASE) << rate_sel) - 32'h1;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (!run) begin
      nxt_st.cnt = 32'h0;
    end else if (st_ff.cnt >= limit) begin
      nxt_st.cnt = 32'h0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 32'h1;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign tick = st_ff.tick;
  a_tick_single: assert property (@(posedge mclk) disable iff (!rst_n)
    tick |=> !tick)
    else $error("wake tick longer than one cycle");
endmodule

// ### src/field_measure_sequencer.sv
// Measurement sequencer with end-of-conversion pulse
`timescale 1ns/1ps
`include "field_measure_cfg.svh"
module field_measure_sequencer #(
  parameter int unsigned CONV_CYC = `CONV_CYC_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] run_mode,
  input wire logic [1:0] chan_cfg,
  input wire logic [2:0] lp_rate,
  input wire logic int_en,
  input wire logic host_trig,
  input wire logic ext_trig,
  input wire logic [11:0] adc_data,
  output logic adc_start,
  output logic [2:0] adc_chan,
  output logic busy,
  output logic eoc_n,
  output logic [11:0] field_x_channel,
  output logic [11:0] field_y_channel,
  output logic [11:0] field_z_channel,
  output logic [11:0] temp_value
);
  localparam int unsigned PULSE_CYC = `EOC_PULSE_CYC;
  typedef struct packed {
    field_measure_pkg::seq_state_t st;
    field_measure_pkg::chan_t ch;
    logic [15:0] conv_cnt;
    logic [7:0] pulse_cnt;
    logic adc_start;
    logic [11:0] rx;
    logic [11:0] ry;
    logic [11:0] rz;
    logic [11:0] rt;
  } seq_t;
  seq_t s_ff;
  seq_t nxt_s;
  logic lp_tick;
  logic trig;
  logic fast;

  // Last channel of a cycle for the configuration
  function automatic field_measure_pkg::chan_t last_chan(input logic [1:0] cfg);
    field_measure_pkg::chan_t r;
    r = field_measure_pkg::CH_T;
    if (cfg == field_measure_pkg::CFG_XYZ) begin
      r = field_measure_pkg::CH_Z;
    end else if (cfg == field_measure_pkg::CFG_XY) begin
      r = field_measure_pkg::CH_Y;
    end
    return r;
  endfunction

  wake_timer u_wake (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(run_mode == field_measure_pkg::MODE_LOW_POWER),
    .rate_sel(lp_rate),
    .tick(lp_tick)
  );

  assign fast = (run_mode == field_measure_pkg::MODE_FAST);
  // Trigger source depends on mode; power down never starts
  always_comb begin
    unique case (run_mode)
      field_measure_pkg::MODE_FAST: trig = 1'b1;
      field_measure_pkg::MODE_LOW_POWER: trig = lp_tick | ext_trig;
      field_measure_pkg::MODE_HOST: trig = host_trig;
      field_measure_pkg::MODE_POWER_DOWN: trig = 1'b0;
    endcase
  end

  always_comb begin
    nxt_s = s_ff;
    nxt_s.adc_start = 1'b0;
    if (s_ff.pulse_cnt != 8'h0) begin
      nxt_s.pulse_cnt = s_ff.pulse_cnt - 8'h1;
    end
    unique case (s_ff.st)
      field_measure_pkg::ST_IDLE: begin
        if (trig) begin
          nxt_s.st = field_measure_pkg::ST_CONV;
          nxt_s.ch = field_measure_pkg::CH_X;
          nxt_s.conv_cnt = 16'h0;
          nxt_s.adc_start = 1'b1;
        end
      end
      field_measure_pkg::ST_CONV: begin
        if (s_ff.conv_cnt >= 16'(CONV_CYC - 1)) begin
          // Only the converted channel is stored; skipped ones hold
          unique case (s_ff.ch)
            field_measure_pkg::CH_X: nxt_s.rx = adc_data;
            field_measure_pkg::CH_Y: nxt_s.ry = adc_data;
            field_measure_pkg::CH_Z: nxt_s.rz = adc_data;
            default: nxt_s.rt = adc_data;
          endcase
          nxt_s.st = field_measure_pkg::ST_NEXT;
        end else begin
          nxt_s.conv_cnt = s_ff.conv_cnt + 16'h1;
        end
      end
      field_measure_pkg::ST_NEXT: begin
        // Also ends a cycle whose configuration shrank mid-way, no channel wrap
        if (s_ff.ch >= last_chan(chan_cfg)) begin
          nxt_s.st = field_measure_pkg::ST_IDLE;
          if (int_en) begin
            nxt_s.pulse_cnt = 8'(PULSE_CYC);
          end
        end else begin
          nxt_s.ch = field_measure_pkg::chan_t'(s_ff.ch + 3'h1);
          nxt_s.conv_cnt = 16'h0;
          nxt_s.adc_start = 1'b1;
          nxt_s.st = field_measure_pkg::ST_CONV;
        end
      end
      default: nxt_s.st = field_measure_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Low outside the pulse is impossible: pulse counter alone drives it
  assign eoc_n = (s_ff.pulse_cnt == 8'h0);
  assign adc_start = s_ff.adc_start;
  assign adc_chan = s_ff.ch;
  assign busy = (s_ff.st != field_measure_pkg::ST_IDLE);
  assign field_x_channel = s_ff.rx;
  assign field_y_channel = s_ff.ry;
  assign field_z_channel = s_ff.rz;
  assign temp_value = s_ff.rt;

  // Assertion helper only: length of the current eoc_n low run
  logic [7:0] eoc_low_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eoc_low_ff <= 8'h00;
    end else if (eoc_n) begin
      eoc_low_ff <= 8'h00;
    end else if (eoc_low_ff != 8'hFF) begin
      eoc_low_ff <= eoc_low_ff + 8'h01;
    end
  end

  a_eoc_width: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(eoc_n) |-> eoc_low_ff == 8'(PULSE_CYC))
    else $error("eoc pulse width wrong");
  a_eoc_max: assert property (@(posedge mclk) disable iff (!rst_n)
    !eoc_n |-> eoc_low_ff < 8'(PULSE_CYC))
    else $error("eoc pulse too long");
  a_eoc_with_end: assert property (@(posedge mclk) disable iff (!rst_n)
    ($fell(busy) && $past(int_en)) |-> !eoc_n)
    else $error("no eoc pulse at cycle end");
  a_eoc_disabled: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_ff.st == field_measure_pkg::ST_NEXT && nxt_s.st == field_measure_pkg::ST_IDLE
     && !int_en && eoc_n) |=> eoc_n)
    else $error("eoc pulsed while disabled");
  a_fast_restart: assert property (@(posedge mclk) disable iff (!rst_n)
    (fast && s_ff.st == field_measure_pkg::ST_IDLE) |=> adc_start)
    else $error("fast mode did not restart");
  a_host_start: assert property (@(posedge mclk) disable iff (!rst_n)
    (run_mode == field_measure_pkg::MODE_HOST && s_ff.st == field_measure_pkg::ST_IDLE
     && !host_trig) |=> !busy)
    else $error("untriggered start");
  a_pd_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    (run_mode == field_measure_pkg::MODE_POWER_DOWN && !busy) |=> !busy)
    else $error("power down started a cycle");
  a_xy_no_z: assert property (@(posedge mclk) disable iff (!rst_n)
    (chan_cfg == field_measure_pkg::CFG_XY) |-> adc_chan <= 3'(field_measure_pkg::CH_Y)
    || !busy || $changed(chan_cfg))
    else $error("xy config converted z or t");
  a_xyz_no_t: assert property (@(posedge mclk) disable iff (!rst_n)
    (chan_cfg == field_measure_pkg::CFG_XYZ && $stable(chan_cfg) && busy)
    |-> adc_chan != 3'(field_measure_pkg::CH_T))
    else $error("xyz config converted t");
  a_skip_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (chan_cfg != field_measure_pkg::CFG_XYZT && adc_chan != 3'(field_measure_pkg::CH_T))
    |=> $stable(temp_value))
    else $error("skipped temperature changed");
  a_order_x_y: assert property (@(posedge mclk) disable iff (!rst_n)
    (adc_start && adc_chan == 3'(field_measure_pkg::CH_Y))
    |-> $past(adc_chan) == 3'(field_measure_pkg::CH_X))
    else $error("y not after x");
  a_order_y_z: assert property (@(posedge mclk) disable iff (!rst_n)
    (adc_start && adc_chan == 3'(field_measure_pkg::CH_Z))
    |-> $past(adc_chan) == 3'(field_measure_pkg::CH_Y))
    else $error("z not after y");
  a_order_z_t: assert property (@(posedge mclk) disable iff (!rst_n)
    (adc_start && adc_chan == 3'(field_measure_pkg::CH_T))
    |-> $past(adc_chan) == 3'(field_measure_pkg::CH_Z))
    else $error("t not after z");
  // Channel register keeps the last converted channel after the cycle ends
  a_xyz_end: assert property (@(posedge mclk) disable iff (!rst_n)
    ($fell(busy) && chan_cfg == field_measure_pkg::CFG_XYZ && $stable(chan_cfg))
    |-> adc_chan == 3'(field_measure_pkg::CH_Z))
    else $error("xyz cycle did not end after z");
  a_xy_end: assert property (@(posedge mclk) disable iff (!rst_n)
    ($fell(busy) && chan_cfg == field_measure_pkg::CFG_XY && $stable(chan_cfg))
    |-> adc_chan == 3'(field_measure_pkg::CH_Y))
    else $error("xy cycle did not end after y");
  c_full_cycle: cover property (@(posedge mclk) disable iff (!rst_n)
    adc_start && adc_chan == 3'(field_measure_pkg::CH_T));
  c_eoc_pulse: cover property (@(posedge mclk) disable iff (!rst_n) $rose(eoc_n));
  c_xy_cycle: cover property (@(posedge mclk) disable iff (!rst_n)
    chan_cfg == field_measure_pkg::CFG_XY && $fell(busy));
  c_lp_start: cover property (@(posedge mclk) disable iff (!rst_n)
    run_mode == field_measure_pkg::MODE_LOW_POWER && $rose(busy));
endmodule

// ### dv/adc_model.sv
// Converter model feeding results to the sequencer
`timescale 1ns/1ps
module adc_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic adc_start,
  input wire logic [2:0] adc_chan,
  output logic [11:0] adc_data
);
  logic [7:0] n_ff;
  // Value carries channel and conversion count, so stale results show
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) n_ff <= 8'h00;
    else if (adc_start) n_ff <= n_ff + 8'h01;
  end
  assign adc_data = {adc_chan[1:0], 2'h0, n_ff};
endmodule

// ### dv/field_measure_sequencer_tb.sv
// Self-checking bench of the measurement sequencer
`timescale 1ns/1ps
`include "field_measure_cfg.svh"
module field_measure_sequencer_tb;
  logic mclk, rst_n, int_en, host_trig, ext_trig, adc_start, busy, eoc_n;
  logic [1:0] run_mode, chan_cfg;
  logic [2:0] lp_rate, adc_chan;
  logic [11:0] adc_data, fx, fy, fz, ft, ez, et;
  int fails, comparisons, cycles, nconv, low, n;
  field_measure_sequencer u_dut (.mclk(mclk), .rst_n(rst_n),
    .run_mode(run_mode), .chan_cfg(chan_cfg), .lp_rate(lp_rate), .int_en(int_en),
    .host_trig(host_trig), .ext_trig(ext_trig), .adc_data(adc_data),
    .adc_start(adc_start), .adc_chan(adc_chan), .busy(busy), .eoc_n(eoc_n),
    .field_x_channel(fx), .field_y_channel(fy), .field_z_channel(fz), .temp_value(ft));
  adc_model u_adc (.mclk(mclk), .rst_n(rst_n), .adc_start(adc_start),
    .adc_chan(adc_chan), .adc_data(adc_data));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Ceiling well above the under two thousand cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function logic [11:0] ev(input logic [1:0] ch, input int k);
    ev = {ch, 2'h0, k[7:0]};
  endfunction
  task final_report();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One host-started cycle, then the low time of eoc_n in cycles
  task trig_cycle(input logic [1:0] cfg);
    @(negedge mclk);
    chan_cfg = cfg;
    host_trig = 1'b1;
    @(negedge mclk);
    host_trig = 1'b0;
    for (n = 0; n < 200 && busy === 1'b1; n++) @(negedge mclk);
    for (low = 0; low < 300 && eoc_n === 1'b0; low++) @(negedge mclk);
    nconv += (cfg == 2'h1) ? 3 : (cfg == 2'h2) ? 2 : 4;
  endtask
  // Results are read as soon as eoc_n rises, early in the host read window
  task t_full();
    trig_cycle(2'h0);
    chk(12'(low), 12'(`EOC_PULSE_CYC));
    chk(fx, ev(2'h0, nconv - 3));
    chk(fy, ev(2'h1, nconv - 2));
    chk(fz, ev(2'h2, nconv - 1));
    chk(ft, ev(2'h3, nconv));
    et = ev(2'h3, nconv);
    $display("test full cycle done");
  endtask
  task t_skip();
    trig_cycle(2'h1);
    chk(fz, ev(2'h2, nconv));
    chk(ft, et);
    ez = ev(2'h2, nconv);
    trig_cycle(2'h2);
    chk(fy, ev(2'h1, nconv));
    chk(fz, ez);
    chk(ft, et);
    $display("test skipped channels done");
  endtask
  task t_noint();
    int_en = 1'b0;
    trig_cycle(2'h3);
    chk(12'(low), 12'h000);
    chk(ft, ev(2'h3, nconv));
    int_en = 1'b1;
    $display("test interrupt off done");
  endtask
  // Host mode must ignore a missing command and the external line
  task t_idle();
    ext_trig = 1'b1;
    low = 0;
    repeat (150) begin
      @(negedge mclk);
      if (busy !== 1'b0) low++;
    end
    ext_trig = 1'b0;
    chk(12'(low), 12'h000);
    $display("test no trigger done");
  endtask
  task t_timer();
    run_mode = field_measure_pkg::MODE_LOW_POWER;
    for (n = 0; n < 80 && busy !== 1'b1; n++) @(negedge mclk);
    chk(12'(busy), 12'h001);
    nconv += 4;
    run_mode = field_measure_pkg::MODE_FAST;
    for (n = 0; n < 200 && busy === 1'b1; n++) @(negedge mclk);
    for (n = 0; n < 5 && busy !== 1'b1; n++) @(negedge mclk);
    chk(12'(n), 12'h001);
    nconv += 4;
    for (n = 0; n < 200 && busy === 1'b1; n++) @(negedge mclk);
    for (n = 0; n < 5 && busy !== 1'b1; n++) @(negedge mclk);
    chk(12'(n), 12'h001);
    // Read paced on the end pulse while the next cycle already converts
    for (n = 0; n < 100 && eoc_n !== 1'b1; n++) @(negedge mclk);
    chk(ft, ev(2'h3, nconv));
    chk(fx, ev(2'h0, nconv + 1));
    nconv += 4;
    run_mode = field_measure_pkg::MODE_POWER_DOWN;
    for (n = 0; n < 200 && busy === 1'b1; n++) @(negedge mclk);
    repeat (120) @(negedge mclk);
    chk(12'(busy), 12'h000);
    $display("test timer and fast done");
  endtask
  // Slowest wake rate keeps the timer quiet, so only the external line starts
  task t_ext();
    lp_rate = 3'h7;
    run_mode = field_measure_pkg::MODE_LOW_POWER;
    ext_trig = 1'b1;
    @(negedge mclk);
    ext_trig = 1'b0;
    chk(12'(busy), 12'h001);
    for (n = 0; n < 200 && busy === 1'b1; n++) @(negedge mclk);
    chk(ft, ev(2'h3, nconv + 4));
    nconv += 4;
    $display("test external trigger done");
  endtask
  initial begin
    rst_n = 1'b0;
    run_mode = field_measure_pkg::MODE_HOST;
    chan_cfg = 2'h0;
    lp_rate = 3'h0;
    int_en = 1'b1;
    host_trig = 1'b0;
    ext_trig = 1'b0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    chk(12'(eoc_n), 12'h001);
    t_full();
    t_skip();
    t_noint();
    t_idle();
    t_timer();
    t_ext();
    final_report();
  end
endmodule
